// ### dv/tb_teletext_page_display_generator.sv
// Purpose: Self-checking bench for the teletext display generator
// Assumes: Short 2400-cycle lines, so only the first rows are drawn
// Notes:   Sandcastle inputs follow the sync inputs
`timescale 1ns/1ps
`default_nettype none
`include "ttx_display_consts.vh"
module tb_teletext_page_display_generator;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic        hs = 1'b0;
  logic        vs = 1'b0;
  logic [9:0]  mem_addr;
  logic        mem_rd;
  logic [7:0]  mem_data;
  logic        red, green, blue, blank, contrast_reduce_out;
  logic [31:0] rdv;
  logic        errv;
  int          failures = 0;
  int          checks = 0;
  localparam logic [7:0] RADDR [7] = '{`A_HDELAY, `A_VDELAY, `A_CUR_ROW, `A_CUR_COL,
                                       `A_TIMING, `A_LANG, `A_CTRL};
  localparam logic [31:0] RMASK [7] = '{32'hFF, 32'h3F, 32'h1F, 32'h3F, 32'hFF, 32'h0F, 32'h1F};
  always #12.5 clk = ~clk;
  teletext_page_display_generator i_dut (
    .CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .HORIZONTAL_SYNC(hs), .VERTICAL_SYNC(vs), .SANDCASTLE_H(hs), .SANDCASTLE_V(vs),
    .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_DATA(mem_data), .RED(red), .GREEN(green),
    .BLUE(blue), .BLANK_OUT(blank), .CONTRAST_REDUCE_OUT(contrast_reduce_out)
  );
  ttx_page_memory i_mem (.clk(clk), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_data(mem_data));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) failures++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic vs_pulse();
    @(posedge clk);
    vs <= 1'b1;
    repeat (4) @(posedge clk);
    vs <= 1'b0;
  endtask
  // One line: offset of first shown pixel, colours in columns 0 and 1
  task automatic line_run(output int off, output logic [2:0] c0, output logic [2:0] c1,
                          output logic cr);
    off = -1;
    c0 = 3'h0;
    c1 = 3'h0;
    cr = 1'b0;
    @(posedge clk);
    hs <= 1'b1;
    for (int i = 1; i < 2400; i++) begin
      @(posedge clk);
      if (i == 4) hs <= 1'b0;
      if (off < 0 && blank === 1'b1) off = i;
      if (off >= 0 && i == off + 18) c0 = {red, green, blue};
      if (off >= 0 && i == off + 54) begin
        c1 = {red, green, blue};
        cr = contrast_reduce_out;
      end
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, RADDR[i], 32'h0);
      chk("reset value", 32'h0, rdv);
      apb(1'b1, RADDR[i], 32'hFFFFFFFF);
      apb(1'b0, RADDR[i], 32'h0);
      chk("readback", RMASK[i], rdv);
      apb(1'b1, RADDR[i], 32'h0);
    end
    apb(1'b1, 8'h20, 32'hFFFFFFFF);
    chk("unmapped write error", 32'h1, errv);
    apb(1'b0, 8'h02, 32'h0);
    chk("unaligned read error", 32'h1, errv);
    chk("unaligned read data", 32'h0, rdv);
    $display("TEST regs done");
  endtask
  task automatic t_flash();
    for (int n = 0; n <= 52; n++) begin
      if (n > 0) vs_pulse();
      apb(1'b0, `A_STATUS, 32'h0);
      chk("flash phase", ((n % 50) < 32), rdv[6]);
    end
    $display("TEST flash done");
  endtask
  task automatic t_rows();
    int off;
    logic [2:0] c0, c1;
    logic cr, vis;
    apb(1'b1, `A_VDELAY, 32'h3);
    apb(1'b1, `A_CTRL, 32'h15);
    vs_pulse();
    for (int n = 1; n <= 20; n++) begin
      if (n == 8) apb(1'b1, `A_CTRL, 32'h14);
      line_run(off, c0, c1, cr);
      vis = (n >= 4) && ((n - 4) / 8 != 1);
      chk("text shown", vis, off >= 0);
      if (vis) begin
        chk("cursor cell", (n < 8) ? 3'h7 : 3'h0, c0);
        chk("background", 3'h0, c1);
        chk("contrast reduce", 1'b1, cr);
      end
    end
    $display("TEST rows done");
  endtask
  task automatic t_hpos();
    int off [3];
    logic [2:0] c0, c1;
    logic cr;
    apb(1'b1, `A_VDELAY, 32'h0);
    apb(1'b1, `A_TIMING, 32'hA0);
    vs_pulse();
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `A_HDELAY, (k == 0) ? 32'h0 : (k == 1) ? 32'h5 : 32'hFF);
      line_run(off[k], c0, c1, cr);
      chk("screen colour", 3'h5, c1);
    end
    chk("delay step", 32'd15, off[1] - off[0]);
    chk("delay max", 32'd765, off[2] - off[0]);
    $display("TEST hpos done");
  endtask
  // ==========================================================
  // Run control
  task automatic wrap_up();
    $display("COUNTS checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_flash();
    t_rows();
    t_hpos();
    wrap_up();
  end
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule // tb_teletext_page_display_generator
`default_nettype wire

// ### dv/ttx_display_properties.sv
// Purpose: Port assertions for the teletext display generator
// Assumes: Bound to the top module, sees its ports only
// Notes:   Background, CONTRAST_REDUCE_OUT enable and vertical delay shadowed from APB writes
`timescale 1ns/1ps
`default_nettype none
`include "ttx_display_consts.vh"
module ttx_display_checker (
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PSLVERR,
  input wire logic        HORIZONTAL_SYNC,
  input wire logic        VERTICAL_SYNC,
  input wire logic [9:0]  MEM_ADDR,
  input wire logic        MEM_RD,
  input wire logic        RED,
  input wire logic        GREEN,
  input wire logic        BLUE,
  input wire logic        BLANK_OUT,
  input wire logic        CONTRAST_REDUCE_OUT
);
  logic [2:0] bg_r;
  logic       cor_en_r;
  logic [5:0] vd_r;
  logic [6:0] hs_cnt_r;
  wire        wr_now = PSEL && PENABLE && PWRITE;
  // ==========================================================
  // Shadow state
  always_ff @(posedge CLK) begin
    if (RESET) begin
      bg_r     <= 3'h0;
      cor_en_r <= 1'b0;
      vd_r     <= 6'h00;
      hs_cnt_r <= 7'h00;
    end else begin
      if (wr_now && PADDR == `A_TIMING) bg_r <= PWDATA[`BG_MSB:`BG_LSB];
      if (wr_now && PADDR == `A_CTRL) cor_en_r <= PWDATA[`CTRL_COR_EN];
      if (wr_now && PADDR == `A_VDELAY) vd_r <= PWDATA[5:0];
      if (VERTICAL_SYNC && !$past(VERTICAL_SYNC)) hs_cnt_r <= 7'h00;
      else if (HORIZONTAL_SYNC && !$past(HORIZONTAL_SYNC) && hs_cnt_r != 7'h7F)
        hs_cnt_r <= hs_cnt_r + 7'h01;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // ==========================================================
  // Assertions
  erase_fetch_a: assert property ($rose(HORIZONTAL_SYNC) |-> ##[1:2]
    (MEM_RD && MEM_ADDR[9:2] == 8'hC8)) else $error("erase flag fetch missing");
  addr_map_a: assert property (MEM_RD |->
    !(MEM_ADDR >= 10'h324 && MEM_ADDR <= 10'h337)) else $error("fetch from unused address");
  fetch_pitch_a: assert property ((MEM_RD && MEM_ADDR[9:2] != 8'hC8) |=>
    (!MEM_RD) [*8]) else $error("character fetches too close");
  bg_outside_a: assert property ((!BLANK_OUT && bg_r == $past(bg_r, 2)) |->
    ({RED, GREEN, BLUE} == bg_r)) else $error("blanked area not background colour");
  cor_idle_a: assert property (!BLANK_OUT |-> !CONTRAST_REDUCE_OUT)
    else $error("contrast reduction outside text");
  cor_gate_a: assert property ((CONTRAST_REDUCE_OUT && cor_en_r == $past(cor_en_r, 2))
    |-> cor_en_r) else $error("contrast reduction while disabled");
  lead_blank_a: assert property ($rose(HORIZONTAL_SYNC) |-> ##2 (!BLANK_OUT) [*8])
    else $error("text shown right after line sync");
  vwin_hold_a: assert property ((hs_cnt_r <= {1'b0, vd_r}) |-> !BLANK_OUT)
    else $error("text shown above vertical window");
  cover property ($rose(BLANK_OUT));
  cover property (CONTRAST_REDUCE_OUT);
  cover property (PSEL && PENABLE && PSLVERR);
endmodule // ttx_display_checker
bind teletext_page_display_generator ttx_display_checker i_chk (
  .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PSLVERR(PSLVERR),
  .HORIZONTAL_SYNC(HORIZONTAL_SYNC), .VERTICAL_SYNC(VERTICAL_SYNC),
  .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .RED(RED), .GREEN(GREEN), .BLUE(BLUE),
  .BLANK_OUT(BLANK_OUT), .CONTRAST_REDUCE_OUT(CONTRAST_REDUCE_OUT)
);
`default_nettype wire

// ### dv/ttx_page_memory.sv
// Purpose: Display memory model on the far side of the fetch port
// Assumes: Data is sampled while the read strobe stands
// Notes:   Idle bus shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module ttx_page_memory (
  input  wire logic       clk,
  input  wire logic       mem_rd,
  input  wire logic [9:0] mem_addr,
  output logic      [7:0] mem_data
);
  logic [7:0] mem [0:1023];
  logic [7:0] last_r = 8'h00;
  // ==========================================================
  // Page content: every cell a harmless control code; erase flag byte 0x320 holds 0x02, blanking row 1
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 8'h09;
    mem[10'h320] = 8'h02;
    mem[10'h321] = 8'h00;
    mem[10'h322] = 8'h00;
    mem[10'h323] = 8'h00;
  end
  // ==========================================================
  // Byte stands with the strobe; idle bus shows the inverse
  always @(posedge clk) begin
    if (mem_rd) begin
      last_r <= mem[mem_addr];
    end
  end
  assign mem_data = mem_rd ? mem[mem_addr] : ~last_r;
endmodule // ttx_page_memory
`default_nettype wire

// ### rtl/teletext_page_display_generator.v
// Purpose: Teletext page display generator with APB registers
// Assumes: Sync inputs and memory data synchronous to CLK
// Notes:   Display memory answers in the same cycle as MEM_RD
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ttx_display_consts.vh"
// Notes on behaviour
// RULE1: Page is 25 rows of 40 characters
// RULE2: Character cell is 12 by 10 pixels
// RULE3: Pixel clock near 12 MHz
// RULE4: Text area spans 250 lines per field
// RULE5: Horizontal start shiftable up to 21.33 us; code allows 255 steps of 3 CLK cycles, 19.125 us at 40 MHz
// RULE6: Vertical start shiftable from line 1 to 64
// RULE7: Cursor swaps colours at programmed cell
// RULE8: Software toggles cursor enable for blinking
// RULE9: Flash hides foreground at 1 Hz, 32:18
// RULE10: Timing bits 7-5 give screen background colour
// RULE11: Row 25 columns 0-3 hold erase flags
// RULE12: Erase flag set means row is blanked
// RULE13: Erase flag fetched at every row start
// RULE14: Row and column map to memory address
// RULE15: Codes below 32 are control characters
// RULE16: Glyph address from code, language, mode bits
// RULE17: 60 Hz mode uses 9 or 8 lines
// RULE18: Store adds overlay and mosaic glyph sets
// RULE19: Overlay 60-7F needs overlay select bit
// RULE20: Pixel timing restarts at each sync
// RULE21: Drives RGB, blanking and contrast reduction
// RULE22: Horizontal delay counted in pixels from sync
// RULE23: Vertical delay counted in lines from sync
// RULE24: Outside window show background, blanking idle
module teletext_page_display_generator (
  input  wire        CLK,
  input  wire        RESET,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  input  wire        HORIZONTAL_SYNC,
  input  wire        VERTICAL_SYNC,
  input  wire        SANDCASTLE_H,
  input  wire        SANDCASTLE_V,
  output reg  [9:0]  MEM_ADDR,
  output reg         MEM_RD,
  input  wire [7:0]  MEM_DATA,
  output reg         RED,
  output reg         GREEN,
  output reg         BLUE,
  output reg         BLANK_OUT,
  output reg         CONTRAST_REDUCE_OUT
);
  localparam [2:0] H_IDLE   = 3'h0;
  localparam [2:0] H_ERASE  = 3'h1;
  localparam [2:0] H_DELAY  = 3'h2;
  localparam [2:0] H_LEAD   = 3'h3;
  localparam [2:0] H_ACTIVE = 3'h4;

  reg  [7:0] horizontal_delay_reg_r;
  reg  [5:0] vertical_delay_reg_r;
  reg  [4:0] cursor_row_reg_r;
  reg  [5:0] cursor_column_reg_r;
  reg  [7:0] display_timing_reg_r;
  reg  [3:0] language_control_reg_r;
  reg  [4:0] ctrl_r;
  reg        hs_d_r;
  reg        vs_d_r;
  reg  [6:0] vcnt_r;
  reg        vin_r;
  reg  [4:0] row_r;
  reg  [3:0] gline_r;
  reg  [5:0] field_r;
  reg  [2:0] hstate_r;
  reg  [1:0] ph_r;
  reg  [7:0] dly_r;
  reg  [3:0] sub_r;
  reg  [5:0] col_r;
  reg        rd_erase_r;
  reg        rd_char_r;
  reg        row_erase_flag_r;
  reg  [2:0] fg_r;
  reg  [2:0] bg_r;
  reg        flash_r;
  reg        mos_r;
  reg        sep_r;
  reg        osd_r;
  reg  [2:0] nx_fg_r;
  reg  [2:0] nx_bg_r;
  reg        nx_flash_r;
  reg        nx_ctrl_r;
  reg  [2:0] cu_fg_r;
  reg  [2:0] cu_bg_r;
  reg        cu_flash_r;
  reg        cu_ctrl_r;
  reg        cu_cursor_r;
  reg [11:0] cu_pix_r;
  reg        glyph_ld_r;
  reg [11:0] nx_pix_r;
  reg  [1:0] gsel;
  reg  [2:0] bg_new;
  reg  [2:0] fg_show;
  reg  [2:0] bg_show;
  reg  [2:0] colour;
  reg        pix_on;
  reg [31:0] rd_mux;
  wire [11:0] glyph_pix;
  wire [3:0]  lpc;
  wire [2:0]  bg_default;
  wire [5:0]  load_col;
  wire        hs_src;
  wire        vs_src;
  wire        hs_rise;
  wire        vs_rise;
  wire        tick;
  wire        slot_end;
  wire        fetch_now;
  wire        flash_vis;
  wire        ctrl_code;

  // ==========================================================
  // Address translation
  function [9:0] cell_addr;
    input [4:0] r;
    input [5:0] c;
    begin
      if (c < `HI_COL) begin
        cell_addr = {r, 5'h00} + {4'h0, c};
      end else begin
        cell_addr = `ADDR_HI_BASE - {2'h0, r, 3'h0} + {7'h00, c[2:0]};
      end
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'h0) && (a <= `A_STATUS);
    end
  endfunction

  // ==========================================================
  // APB slave, zero wait states
  assign PREADY  = PSEL & PENABLE;
  assign PSLVERR = PSEL & PENABLE & ~mapped(PADDR);

  always @* begin
    case (PADDR)
      `A_HDELAY:  rd_mux = {24'h0, horizontal_delay_reg_r};
      `A_VDELAY:  rd_mux = {26'h0, vertical_delay_reg_r};
      `A_CUR_ROW: rd_mux = {27'h0, cursor_row_reg_r};
      `A_CUR_COL: rd_mux = {26'h0, cursor_column_reg_r};
      `A_TIMING:  rd_mux = {24'h0, display_timing_reg_r};
      `A_LANG:    rd_mux = {28'h0, language_control_reg_r};
      `A_CTRL:    rd_mux = {27'h0, ctrl_r};
      `A_STATUS:  rd_mux = {24'h0, row_erase_flag_r, flash_vis, vin_r, row_r};
      default:    rd_mux = 32'h0;
    endcase
  end

  always @(posedge CLK) begin
    if (RESET) begin
      PRDATA                 <= 32'h0;
      horizontal_delay_reg_r <= 8'h00;
      vertical_delay_reg_r   <= 6'h00;
      cursor_row_reg_r       <= 5'h00;
      cursor_column_reg_r    <= 6'h00;
      display_timing_reg_r   <= 8'h00;
      language_control_reg_r <= 4'h0;
      ctrl_r                 <= 5'h00;
    end else begin
      if (PSEL & ~PENABLE) begin
        PRDATA <= rd_mux;
      end
      if (PSEL & PENABLE & PWRITE) begin
        case (PADDR)
          `A_HDELAY:  horizontal_delay_reg_r <= PWDATA[7:0]; // [RULE5]
          `A_VDELAY:  vertical_delay_reg_r   <= PWDATA[5:0]; // [RULE6]
          `A_CUR_ROW: cursor_row_reg_r       <= PWDATA[4:0];
          `A_CUR_COL: cursor_column_reg_r    <= PWDATA[5:0];
          `A_TIMING:  display_timing_reg_r   <= PWDATA[7:0];
          `A_LANG:    language_control_reg_r <= PWDATA[3:0];
          `A_CTRL:    ctrl_r                 <= PWDATA[4:0];
          default: ;
        endcase
      end
    end
  end

  assign bg_default = display_timing_reg_r[`BG_MSB:`BG_LSB]; // [RULE10]
  assign lpc = (ctrl_r[2:1] == `LPC_SEL_9) ? `CHARS_LPC9 :
               (ctrl_r[2:1] == `LPC_SEL_8) ? `CHARS_LPC8 : `CHARS_LPC10; // [RULE17]

  // ==========================================================
  // Sync edges; source is sandcastle or separate syncs
  assign hs_src  = ctrl_r[`CTRL_SC_SEL] ? SANDCASTLE_H : HORIZONTAL_SYNC; // [RULE20]
  assign vs_src  = ctrl_r[`CTRL_SC_SEL] ? SANDCASTLE_V : VERTICAL_SYNC;
  assign hs_rise = hs_src & ~hs_d_r;
  assign vs_rise = vs_src & ~vs_d_r;
  assign flash_vis = field_r < `FLASH_ON; // [RULE9]

  // ==========================================================
  // Vertical timing
  always @(posedge CLK) begin
    if (RESET) begin
      hs_d_r  <= 1'b0;
      vs_d_r  <= 1'b0;
      vcnt_r  <= 7'h00;
      vin_r   <= 1'b0;
      row_r   <= 5'h00;
      gline_r <= 4'h0;
      field_r <= 6'h00;
    end else begin
      hs_d_r <= hs_src;
      vs_d_r <= vs_src;
      if (vs_rise) begin
        vcnt_r  <= 7'h00;
        vin_r   <= 1'b0;
        // Fifty fields make one flash period at 50 Hz
        field_r <= (field_r == `FLASH_FIELDS - 6'h01) ? 6'h00 : field_r + 6'h01; // [RULE9]
      end else if (hs_rise) begin
        if (vcnt_r != `VCNT_MAX) begin
          vcnt_r <= vcnt_r + 7'h01;
        end
        if (!vin_r && vcnt_r == {1'b0, vertical_delay_reg_r}) begin // [RULE23]
          vin_r   <= 1'b1;
          row_r   <= 5'h00;
          gline_r <= 4'h0;
        end else if (vin_r) begin
          if (gline_r == lpc - 4'h1) begin // [RULE2]
            gline_r <= 4'h0;
            if (row_r == `LAST_ROW) begin // [RULE1] [RULE4]
              vin_r <= 1'b0;
            end else begin
              row_r <= row_r + 5'h01;
            end
          end else begin
            gline_r <= gline_r + 4'h1;
          end
        end
      end
    end
  end

  // ==========================================================
  // Horizontal timing and memory fetch
  assign tick      = (ph_r == `PIX_PH_LAST); // [RULE3]
  assign slot_end  = tick && (sub_r == `LAST_SUB);
  assign fetch_now = (sub_r == 4'h0) && (ph_r == `FETCH_PH) &&
                     (hstate_r == H_LEAD || (hstate_r == H_ACTIVE && col_r != `LAST_COL));
  assign load_col  = (hstate_r == H_LEAD) ? 6'h00 : col_r + 6'h01;
  assign ctrl_code = MEM_DATA < `CTRL_LIMIT; // [RULE15]

  always @(posedge CLK) begin
    if (RESET) begin
      hstate_r   <= H_IDLE;
      ph_r       <= 2'h0;
      dly_r      <= 8'h00;
      sub_r      <= 4'h0;
      col_r      <= 6'h00;
      MEM_ADDR   <= 10'h000;
      MEM_RD     <= 1'b0;
      rd_erase_r <= 1'b0;
      rd_char_r  <= 1'b0;
    end else begin
      MEM_RD     <= 1'b0;
      rd_erase_r <= 1'b0;
      rd_char_r  <= 1'b0;
      ph_r       <= tick ? 2'h0 : ph_r + 2'h1;
      if (hs_rise) begin
        hstate_r <= H_ERASE;
      end else begin
        case (hstate_r)
          H_ERASE: begin
            // Flags refetched every line, so a row never uses a stale one
            MEM_ADDR   <= cell_addr(`ERASE_ROW, {4'h0, row_r[4:3]}); // [RULE11] [RULE13]
            MEM_RD     <= 1'b1;
            rd_erase_r <= 1'b1;
            ph_r       <= 2'h0; // [RULE20]
            dly_r      <= 8'h00;
            hstate_r   <= H_DELAY;
          end
          H_DELAY: begin
            if (dly_r == horizontal_delay_reg_r) begin // [RULE22]
              hstate_r <= H_LEAD;
              ph_r     <= 2'h0;
              sub_r    <= 4'h0;
            end else if (tick) begin
              dly_r <= dly_r + 8'h01;
            end
          end
          H_LEAD, H_ACTIVE: begin
            if (fetch_now) begin
              MEM_ADDR  <= cell_addr(row_r, load_col); // [RULE14]
              MEM_RD    <= 1'b1;
              rd_char_r <= 1'b1;
            end
            if (tick) begin
              sub_r <= slot_end ? 4'h0 : sub_r + 4'h1;
            end
            if (slot_end) begin
              col_r <= load_col;
              if (hstate_r == H_LEAD) begin
                hstate_r <= H_ACTIVE;
              end else if (col_r == `LAST_COL) begin
                hstate_r <= H_IDLE;
              end
            end
          end
          default: hstate_r <= H_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Serial attributes and glyph selection
  always @* begin
    gsel = `SEL_TEXT;
    if (MEM_DATA[7] ||
        (osd_r && language_control_reg_r[`OVL_BIT] && MEM_DATA >= `OVL_LOW)) begin // [RULE19]
      gsel = `SEL_OSD; // [RULE18]
    end else if (mos_r && MEM_DATA[5]) begin
      gsel = `SEL_MOSAIC; // [RULE18]
    end
    bg_new = bg_r;
    if (ctrl_code && MEM_DATA[4:0] == `C_BLACK_BG) begin
      bg_new = `BLACK;
    end else if (ctrl_code && MEM_DATA[4:0] == `C_NEW_BG) begin
      bg_new = fg_r;
    end
  end

  ttx_glyph_store u_glyph (
    .clk   (CLK),
    .sel   (gsel),
    .sep   (sep_r),
    .lang  (language_control_reg_r[2:0]),
    .code  (MEM_DATA[6:0]),
    .line  (gline_r),
    .pix_r (glyph_pix)
  ); // [RULE16]

  always @(posedge CLK) begin
    if (RESET) begin
      row_erase_flag_r <= 1'b0;
      fg_r <= `WHITE;
      bg_r <= `BLACK;
      {flash_r, mos_r, sep_r, osd_r} <= 4'h0;
      {nx_fg_r, nx_bg_r, nx_flash_r, nx_ctrl_r} <= 8'h00;
      {cu_fg_r, cu_bg_r, cu_flash_r, cu_ctrl_r, cu_cursor_r} <= 9'h000;
      cu_pix_r <= 12'h000;
      glyph_ld_r <= 1'b0;
      nx_pix_r <= 12'h000;
    end else begin
      // Glyph register is valid only the cycle after the fetch
      glyph_ld_r <= rd_char_r;
      if (glyph_ld_r) begin
        nx_pix_r <= glyph_pix; // [RULE16]
      end
      if (rd_erase_r) begin
        // Unused bits above row 24 are never selected
        row_erase_flag_r <= MEM_DATA[row_r[2:0]]; // [RULE11]
      end
      if (hstate_r == H_DELAY) begin
        // Row start defaults
        fg_r <= `WHITE;
        bg_r <= bg_default; // [RULE10]
        {flash_r, mos_r, sep_r, osd_r} <= 4'h0;
      end else if (rd_char_r) begin
        nx_fg_r    <= fg_r;
        nx_flash_r <= flash_r;
        nx_bg_r    <= bg_new;
        nx_ctrl_r  <= ctrl_code; // [RULE15]
        bg_r       <= bg_new;
        if (ctrl_code) begin
          if (MEM_DATA[3] == 1'b0) begin
            fg_r  <= MEM_DATA[2:0];
            mos_r <= MEM_DATA[4];
          end
          case (MEM_DATA[4:0])
            `C_FLASH:  flash_r <= 1'b1;
            `C_STEADY: flash_r <= 1'b0;
            `C_CONTIG: sep_r   <= 1'b0;
            `C_SEPAR:  sep_r   <= 1'b1;
            `C_OSD:    osd_r   <= ~osd_r;
            default: ;
          endcase
        end
      end
      if (slot_end) begin
        cu_fg_r     <= nx_fg_r;
        cu_bg_r     <= nx_bg_r;
        cu_flash_r  <= nx_flash_r;
        cu_ctrl_r   <= nx_ctrl_r;
        cu_pix_r    <= nx_pix_r;
        cu_cursor_r <= ctrl_r[`CTRL_CUR_EN] && row_r == cursor_row_reg_r &&
                       load_col == cursor_column_reg_r; // [RULE7]
      end
    end
  end

  // ==========================================================
  // Pixel output stage
  always @* begin
    pix_on  = cu_pix_r[`LAST_SUB - sub_r] & ~cu_ctrl_r;
    fg_show = cu_fg_r;
    bg_show = cu_bg_r;
    if (cu_cursor_r) begin
      fg_show = cu_bg_r; // [RULE7]
      bg_show = cu_fg_r;
    end
    if (cu_flash_r && !flash_vis) begin
      fg_show = bg_show; // [RULE9]
    end
    colour = pix_on ? fg_show : bg_show;
  end

  always @(posedge CLK) begin
    if (RESET) begin
      {RED, GREEN, BLUE} <= `BLACK;
      BLANK_OUT <= 1'b0;
      CONTRAST_REDUCE_OUT <= 1'b0;
    end else if (hstate_r == H_ACTIVE && vin_r && !row_erase_flag_r) begin // [RULE12]
      {RED, GREEN, BLUE} <= colour; // [RULE21]
      BLANK_OUT <= 1'b1;
      CONTRAST_REDUCE_OUT <= ctrl_r[`CTRL_COR_EN] & ~pix_on;
    end else begin
      {RED, GREEN, BLUE} <= bg_default; // [RULE24]
      BLANK_OUT <= 1'b0;
      CONTRAST_REDUCE_OUT <= 1'b0;
    end
  end
endmodule // teletext_page_display_generator
`default_nettype wire

// ### rtl/ttx_display_consts.vh
// Purpose: Constants of the teletext page display generator
// Assumes: Included by the display design files, the bench and the checker; the memory model does not include it
// Notes:   Register offsets are APB byte addresses
`ifndef TTX_DISPLAY_CONSTS_VH
`define TTX_DISPLAY_CONSTS_VH
// ==========================================================
// Timing
`define CLK_MHZ       40
`define PIX_MHZ       12
`define PIX_CYC       (`CLK_MHZ / `PIX_MHZ)
`define PIX_PH_LAST   2'h2
`define FETCH_PH      2'h1
`define FLASH_FIELDS  6'h32
`define FLASH_ON      6'h20
`define VCNT_MAX      7'h7F
// ==========================================================
// Page geometry
`define LAST_ROW      5'h18
`define LAST_COL      6'h27
`define LAST_SUB      4'hB
`define ERASE_ROW     5'h19
`define HI_COL        6'h20
`define ADDR_HI_BASE  10'h3F8
`define CHARS_LPC10   4'hA
`define CHARS_LPC9    4'h9
`define CHARS_LPC8    4'h8
`define LPC_SEL_9     2'h1
`define LPC_SEL_8     2'h2
// ==========================================================
// Character codes
`define CTRL_LIMIT    8'h20
`define OVL_LOW       8'h60
`define C_FLASH       5'h08
`define C_STEADY      5'h09
`define C_CONTIG      5'h19
`define C_SEPAR       5'h1A
`define C_OSD         5'h1B
`define C_BLACK_BG    5'h1C
`define C_NEW_BG      5'h1D
`define WHITE         3'h7
`define BLACK         3'h0
`define SEL_TEXT      2'h0
`define SEL_MOSAIC    2'h1
`define SEL_OSD       2'h2
// ==========================================================
// Registers
`define A_HDELAY      8'h00
`define A_VDELAY      8'h04
`define A_CUR_ROW     8'h08
`define A_CUR_COL     8'h0C
`define A_TIMING      8'h10
`define A_LANG        8'h14
`define A_CTRL        8'h18
`define A_STATUS      8'h1C
`define BG_MSB        7
`define BG_LSB        5
`define OVL_BIT       3
`define CTRL_CUR_EN   0
`define CTRL_SC_SEL   3
`define CTRL_COR_EN   4
`endif

// ### rtl/ttx_glyph_store.v
// Purpose: Glyph store, one pixel line of one glyph per lookup
// Assumes: Lookup issued one cycle before data is used
// Notes:   Text and overlay patterns are stand-ins for a font table
`timescale 1ns/1ps
`default_nettype none
`include "ttx_display_consts.vh"
module ttx_glyph_store (
  input  wire        clk,
  input  wire [1:0]  sel,
  input  wire        sep,
  input  wire [2:0]  lang,
  input  wire [6:0]  code,
  input  wire [3:0]  line,
  output reg  [11:0] pix_r
);
  reg [1:0] band;
  reg [1:0] cells;
  reg [5:0] half;
  reg [11:0] pix_nxt;
  // ==========================================================
  // Sixel mosaics: 2 x 3 blocks, separated mode leaves gaps
  always @* begin
    band = (line < 4'h3) ? 2'h0 : (line < 4'h7) ? 2'h1 : 2'h2;
    case (band)
      2'h0:    cells = code[1:0];
      2'h1:    cells = code[3:2];
      default: cells = {code[6], code[4]};
    endcase
    half = 6'h3F;
    if (sep) begin
      half = 6'h1E;
    end
    pix_nxt = 12'h000;
    case (sel)
      `SEL_MOSAIC: begin
        pix_nxt = {cells[0] ? half : 6'h00, cells[1] ? half : 6'h00};
        if (sep && (line == 4'h2 || line == 4'h6 || line == 4'h9)) begin
          pix_nxt = 12'h000;
        end
      end
      `SEL_OSD: begin
        pix_nxt = (line == 4'h0 || line == 4'h9) ? 12'hFFF :
                  {1'b1, code[4:0], lang, line[2:0]} | 12'h001;
      end
      default: begin
        if (line != 4'h0 && line != 4'h9) begin
          pix_nxt = {2'h0, code[5:0] ^ {lang, line[2:0]}, 4'h0};
        end
      end
    endcase
  end
  always @(posedge clk) begin
    pix_r <= pix_nxt;
  end
endmodule // ttx_glyph_store
`default_nettype wire
